//--- logic/rsq_ramp_seq.sv
`timescale 1ns/1ps
`include "rsq_consts.svh"
// Function
// R1: a ramp mode setting lets a four-stage program drive the main output.
// R2: start by command when enabled; in auto also at power-up, button, binary input.
// R3: stage 1 moves the target toward threshold one at the gradient per second.
// R4: stage 2 holds threshold one with band one; infinite hold value stays.
// R5: stage 3 drives the main output fully on until threshold two is reached.
// R6: stage 4 holds threshold two with band two; infinite hold value stays.
// R7: after stage 4 the end state keeps the main output off.
// R8: after-end-on auxiliary output is off while running, on after the end.
// R9: after-end-off auxiliary output is on while running, off after the end.
// R10: late-stage auxiliary output is on only in stages 3 and 4.
// R11: a running program blocks autotuning start and PID parameter adjustment.
// R12: manual mode sets output level 0 to 100 percent, independent of measurement.
// R13: manual mode is selectable per output, the analogue output included.
// R14: button or binary input, when configured, enter unconditional manual mode.
// R15: emergency manual setting forces an output manual on sensor error.
// R16: switched manual outputs pulse with duty equal to level, configured period.
// R17: level 0 holds the output off, level 100 holds it on.
// R18: manual level changes from up/down keys, quick menu or configuration writes.
// R19: latched autotuning error clears only with up and down pressed together.
// R20: the remote host uses the configured slave address and baud rate; no such interface here, only the bus_i register port.
// R21: every output is recomputed and updated once per second; here only sw_out_o and ana_level_o, status flags update every clock.
// R22: hold timer starts on first entry to the band, advances on expiry.
module rsq_ramp_seq #(
  parameter int unsigned SEC_CYCLES = `RSQ_SEC_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire rsq_pkg::rsq_bus_t bus_i,
  output logic [15:0]            rdata_o,
  input  wire logic [15:0]       pv_i,
  input  wire logic              sensor_err_i,
  input  wire logic              tune_err_i,
  input  wire logic              func_btn_i,
  input  wire logic              binary_control_input_i,
  input  wire logic              key_up_i,
  input  wire logic              key_down_i,
  output logic [2:0]             sw_out_o,
  output logic [6:0]             ana_level_o,
  output logic                   tune_block_o,
  output logic                   pid_adj_block_o,
  output logic                   forced_manual_o,
  output logic                   tune_err_o,
  output rsq_pkg::rsq_stage_t    stage_o
);
  import rsq_pkg::*;

  // ========================================================================
  // configuration registers
  logic [15:0] ramp_cfg;
  logic [15:0] thr1;
  logic [15:0] thr2;
  logic [15:0] hys1;
  logic [15:0] hys2;
  logic [15:0] grad;
  logic [15:0] hold1;
  logic [15:0] hold2;
  logic [15:0] out_func;
  logic [3:0]  emerg;
  logic [6:0]  man_level;
  logic [6:0]  period;

  logic        wr_cfg;
  assign wr_cfg = bus_i.we;

  // plain configuration storage, written by software
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ramp_cfg <= `RSQ_RST_WORD;
      thr1     <= `RSQ_RST_WORD;
      thr2     <= `RSQ_RST_WORD;
      hys1     <= `RSQ_RST_WORD;
      hys2     <= `RSQ_RST_WORD;
      grad     <= `RSQ_RST_WORD;
      hold1    <= `RSQ_RST_WORD;
      hold2    <= `RSQ_RST_WORD;
      out_func <= `RSQ_RST_WORD;
      emerg    <= 4'h0;
      period   <= `RSQ_RST_PERIOD;
    end else if (wr_cfg) begin
      unique case (bus_i.addr)
        `RSQ_A_RAMP_CFG: ramp_cfg <= bus_i.wdata;
        `RSQ_A_THR1:     thr1     <= bus_i.wdata;
        `RSQ_A_THR2:     thr2     <= bus_i.wdata;
        `RSQ_A_HYS1:     hys1     <= bus_i.wdata;
        `RSQ_A_HYS2:     hys2     <= bus_i.wdata;
        `RSQ_A_GRAD:     grad     <= bus_i.wdata;
        `RSQ_A_HOLD1:    hold1    <= bus_i.wdata;
        `RSQ_A_HOLD2:    hold2    <= bus_i.wdata;
        `RSQ_A_OUT_FUNC: out_func <= bus_i.wdata; // R13
        `RSQ_A_EMERG:    emerg    <= bus_i.wdata[3:0];
        `RSQ_A_PERIOD:   period   <= bus_i.wdata[6:0];
        default: ;
      endcase
    end
  end

  logic [1:0] ramp_mode;
  logic [1:0] btn_cfg;
  logic [1:0] binary_cfg;
  assign ramp_mode  = ramp_cfg[`RSQ_CFG_MODE_LO +: 2];
  assign btn_cfg    = ramp_cfg[`RSQ_CFG_BTN_LO +: 2];
  assign binary_cfg = ramp_cfg[`RSQ_CFG_BINARY_LO +: 2];

  // ========================================================================
  // pin synchronisers: button, binary input, up, down
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_d;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_d  <= 4'h0;
    end else begin
      pin_s1 <= {key_down_i, key_up_i, binary_control_input_i, func_btn_i};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  logic [3:0] pin_rise;
  logic       both_keys;
  assign pin_rise  = pin_s2 & ~pin_d;
  // the pair counts only on the edge that completes it, so a held pair acts once
  assign both_keys = pin_s2[2] & pin_s2[3] & (pin_rise[2] | pin_rise[3]);

  // ========================================================================
  // one-second update tick
  logic tick;
  rsq_tick #(
    .CYCLES (SEC_CYCLES)
  ) u_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_o   (tick)
  );

  // ========================================================================
  // start and stop requests, held until the next tick; set wins over clear
  logic boot_pend;
  logic start_ev;
  logic stop_ev;
  logic start_req;
  logic stop_req;

  assign start_ev = (bus_i.we && bus_i.addr == `RSQ_A_CTRL && bus_i.wdata[`RSQ_CTRL_START]
                     && ramp_mode != `RSQ_MODE_OFF)
                  | ((ramp_mode == `RSQ_MODE_AUTO)
                     & ((tick & boot_pend)
                        | (pin_rise[0] & (btn_cfg == `RSQ_IN_START))
                        | (pin_rise[1] & (binary_cfg == `RSQ_IN_START)))); // R2
  assign stop_ev  = bus_i.we && bus_i.addr == `RSQ_A_CTRL && bus_i.wdata[`RSQ_CTRL_STOP];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_pend <= 1'b1;
      start_req <= 1'b0;
      stop_req  <= 1'b0;
    end else begin
      if (tick) begin
        boot_pend <= 1'b0;
      end
      // an event on the tick edge survives to the following tick instead of being lost
      start_req <= (start_req & ~tick) | start_ev; // R2
      stop_req  <= (stop_req & ~tick) | stop_ev;
    end
  end

  // ========================================================================
  // hysteresis helper: on at or below target minus band, off at target
  function automatic logic hyst_on(input logic [15:0] pv, input logic [15:0] tgt,
                                   input logic [15:0] h, input logic cur);
    logic signed [16:0] lo;
    lo = $signed({tgt[15], tgt}) - $signed({1'b0, h});
    if ($signed({pv[15], pv}) <= lo) begin
      return 1'b1;
    end else if ($signed(pv) >= $signed(tgt)) begin
      return 1'b0;
    end else begin
      return cur;
    end
  endfunction

  function automatic logic in_band(input logic [15:0] pv, input logic [15:0] tgt,
                                   input logic [15:0] h);
    logic signed [17:0] d;
    d = $signed({{2{pv[15]}}, pv}) - $signed({{2{tgt[15]}}, tgt});
    return (d <= $signed({2'b00, h})) && (d >= -$signed({2'b00, h}));
  endfunction

  // ========================================================================
  // program sequencer, advanced on the tick only
  rsq_stage_t         stage;
  logic [15:0]        sp;
  logic [15:0]        hold_tmr;
  logic               band_seen;
  logic               ramp_out;
  logic signed [16:0] sp_up;
  logic signed [16:0] sp_dn;
  logic               band1;
  logic               band2;

  assign sp_up = $signed({sp[15], sp}) + $signed({1'b0, grad});
  assign sp_dn = $signed({sp[15], sp}) - $signed({1'b0, grad});
  assign band1 = in_band(pv_i, thr1, hys1);
  assign band2 = in_band(pv_i, thr2, hys2);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage     <= RSQ_IDLE;
      sp        <= `RSQ_RST_WORD;
      hold_tmr  <= `RSQ_RST_WORD;
      band_seen <= 1'b0;
    end else if (tick) begin
      if (stop_req || ramp_mode == `RSQ_MODE_OFF) begin
        stage <= RSQ_IDLE;
      end else begin
        unique case (stage)
          RSQ_IDLE, RSQ_END: begin
            if (start_req) begin
              stage     <= RSQ_ST1; // R1
              sp        <= pv_i;
              hold_tmr  <= `RSQ_RST_WORD;
              band_seen <= 1'b0;
            end
          end
          RSQ_ST1: begin
            // zero gradient means no rate limit
            if (grad == `RSQ_RST_WORD || sp == thr1) begin
              sp    <= thr1;
              stage <= RSQ_ST2;
            end else if ($signed(sp) < $signed(thr1)) begin
              sp <= (sp_up >= $signed({thr1[15], thr1})) ? thr1 : sp_up[15:0]; // R3
            end else begin
              sp <= (sp_dn <= $signed({thr1[15], thr1})) ? thr1 : sp_dn[15:0]; // R3
            end
          end
          RSQ_ST2: begin
            if (band_seen || band1) begin
              band_seen <= 1'b1; // R22
              hold_tmr  <= hold_tmr + 16'h0001;
              if (hold1 != `RSQ_HOLD_INF && hold_tmr + 16'h0001 >= hold1) begin
                stage     <= RSQ_ST3; // R4
                hold_tmr  <= `RSQ_RST_WORD;
                band_seen <= 1'b0;
              end
            end
          end
          RSQ_ST3: begin
            if ($signed(pv_i) >= $signed(thr2)) begin
              stage <= RSQ_ST4; // R5
            end
          end
          RSQ_ST4: begin
            if (band_seen || band2) begin
              band_seen <= 1'b1; // R22
              hold_tmr  <= hold_tmr + 16'h0001;
              if (hold2 != `RSQ_HOLD_INF && hold_tmr + 16'h0001 >= hold2) begin
                stage     <= RSQ_END; // R6
                hold_tmr  <= `RSQ_RST_WORD;
                band_seen <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // main control value for the current stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ramp_out <= 1'b0;
    end else if (tick) begin
      unique case (stage)
        RSQ_ST1:  ramp_out <= hyst_on(pv_i, sp, hys1, ramp_out);
        RSQ_ST2:  ramp_out <= hyst_on(pv_i, thr1, hys1, ramp_out); // R4
        RSQ_ST3:  ramp_out <= 1'b1; // R5
        RSQ_ST4:  ramp_out <= hyst_on(pv_i, thr2, hys2, ramp_out); // R6
        RSQ_END:  ramp_out <= 1'b0; // R7
        RSQ_IDLE: ramp_out <= 1'b0;
      endcase
    end
  end

  logic active;
  assign active = (stage == RSQ_ST1) | (stage == RSQ_ST2) | (stage == RSQ_ST3) | (stage == RSQ_ST4);

  // ========================================================================
  // manual level: register writes and front keys, keys act only while output 1 is manual
  logic [3:0] man_eff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      man_level <= 7'h00;
    end else if (bus_i.we && bus_i.addr == `RSQ_A_MAN_LEVEL) begin
      man_level <= (bus_i.wdata > 16'(`RSQ_PCT_FULL)) ? `RSQ_PCT_FULL : bus_i.wdata[6:0]; // R18
    end else if (man_eff[0] && !pin_s2[3] && pin_rise[2] && man_level < `RSQ_PCT_FULL) begin
      man_level <= man_level + 7'h01; // R18
    end else if (man_eff[0] && !pin_s2[2] && pin_rise[3] && man_level != 7'h00) begin
      man_level <= man_level - 7'h01; // R18
    end
  end

  // unconditional manual: button toggles, binary input holds while asserted
  logic btn_man;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      btn_man <= 1'b0;
    end else if (btn_cfg != `RSQ_IN_MANUAL) begin
      btn_man <= 1'b0;
    end else if (pin_rise[0]) begin
      btn_man <= ~btn_man; // R14
    end
  end

  logic forced;
  assign forced = btn_man | (pin_s2[1] & (binary_cfg == `RSQ_IN_MANUAL)); // R14

  // per-output manual decision
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      man_eff[i] = (out_func[4*i +: 4] == `RSQ_FN_MANUAL) | forced | (emerg[i] & sensor_err_i); // R13 R15
    end
  end

  // ========================================================================
  // switched outputs: pulse trains and program-tied functions
  logic [2:0] pwm_on;
  logic [2:0] next_sw;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pwm
      rsq_pwm u_pwm (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .tick_i   (tick),
        .level_i  (man_level),
        .period_i (period),
        .on_o     (pwm_on[g])
      );
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      unique case (out_func[4*i +: 4])
        `RSQ_FN_CONTROL: next_sw[i] = ramp_out;
        `RSQ_FN_END_ON:  next_sw[i] = (stage == RSQ_END); // R8
        `RSQ_FN_END_OFF: next_sw[i] = active; // R9
        `RSQ_FN_LATE:    next_sw[i] = (stage == RSQ_ST3) | (stage == RSQ_ST4); // R10
        default:         next_sw[i] = 1'b0;
      endcase
      if (man_eff[i]) begin
        next_sw[i] = pwm_on[i]; // R12 R16 R17
      end
    end
  end

  // outputs move only on the tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_out_o    <= 3'h0;
      ana_level_o <= 7'h00;
    end else if (tick) begin
      sw_out_o <= next_sw; // R21
      if (man_eff[3]) begin
        ana_level_o <= man_level; // R12
      end else if (out_func[15:12] == `RSQ_FN_CONTROL) begin
        ana_level_o <= ramp_out ? `RSQ_PCT_FULL : 7'h00;
      end else begin
        ana_level_o <= 7'h00;
      end
    end
  end

  // ========================================================================
  // status flags; a new tuning error beats the key clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tune_err_o      <= 1'b0;
      tune_block_o    <= 1'b0;
      pid_adj_block_o <= 1'b0;
      forced_manual_o <= 1'b0;
      stage_o         <= RSQ_IDLE;
    end else begin
      tune_err_o      <= tune_err_i | (tune_err_o & ~both_keys); // R19
      tune_block_o    <= active; // R11
      pid_adj_block_o <= active; // R11
      forced_manual_o <= forced;
      stage_o         <= stage;
    end
  end

  // ========================================================================
  // register read port, data in the following cycle only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (!bus_i.re) begin
      rdata_o <= 16'h0000;
    end else begin
      unique case (bus_i.addr)
        `RSQ_A_RAMP_CFG:  rdata_o <= ramp_cfg;
        `RSQ_A_THR1:      rdata_o <= thr1;
        `RSQ_A_THR2:      rdata_o <= thr2;
        `RSQ_A_HYS1:      rdata_o <= hys1;
        `RSQ_A_HYS2:      rdata_o <= hys2;
        `RSQ_A_GRAD:      rdata_o <= grad;
        `RSQ_A_HOLD1:     rdata_o <= hold1;
        `RSQ_A_HOLD2:     rdata_o <= hold2;
        `RSQ_A_OUT_FUNC:  rdata_o <= out_func;
        `RSQ_A_EMERG:     rdata_o <= {12'h000, emerg};
        `RSQ_A_MAN_LEVEL: rdata_o <= {9'h000, man_level};
        `RSQ_A_PERIOD:    rdata_o <= {9'h000, period};
        `RSQ_A_STATUS:    rdata_o <= {4'h0, sw_out_o, tune_err_o, forced, sensor_err_i, stage};
        `RSQ_A_TIMER:     rdata_o <= hold_tmr;
        default:          rdata_o <= 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_END_OFF: assert property (tick && stage == RSQ_END |=> !ramp_out) // R7
    else $error("main output on in end state");
  AST_ST3_FULL: assert property (tick && stage == RSQ_ST3 |=> ramp_out) // R5
    else $error("main output not full in stage 3");
  AST_LATE: assert property (tick && out_func[7:4] == `RSQ_FN_LATE && !man_eff[1]
    |=> sw_out_o[1] == ($past(stage) == RSQ_ST3 || $past(stage) == RSQ_ST4)) // R10
    else $error("late-stage output wrong");
  AST_END_ON: assert property (tick && out_func[11:8] == `RSQ_FN_END_ON && !man_eff[2]
    |=> sw_out_o[2] == ($past(stage) == RSQ_END)) // R8
    else $error("after-end-on output wrong");
  AST_BLOCK: assert property (stage == RSQ_ST2 |=> tune_block_o && pid_adj_block_o) // R11
    else $error("tuning not blocked while running");
  AST_MAN0: assert property (tick && man_eff[0] && man_level == 7'h00 |=> !sw_out_o[0]) // R17
    else $error("level 0 drove output on");
  AST_MAN100: assert property (tick && man_eff[0] && man_level == `RSQ_PCT_FULL |=> sw_out_o[0]) // R17
    else $error("level 100 left output off");
  AST_TUNE_CLR: assert property ($fell(tune_err_o) |-> $past(both_keys)) // R19
    else $error("tuning error cleared without both keys");
  AST_TICK_ONLY: assert property (!$past(tick) |-> $stable(sw_out_o)) // R21
    else $error("switched output moved off the tick");
  AST_HOLD_INF: assert property (tick && stage == RSQ_ST2 && hold1 == `RSQ_HOLD_INF && !stop_req
    && ramp_mode != `RSQ_MODE_OFF |=> stage == RSQ_ST2) // R4
    else $error("infinite hold left stage 2");

  COV_END: cover property (stage == RSQ_ST4 ##1 stage == RSQ_END);
  COV_FORCED: cover property (tick && forced && man_eff[0]);
  COV_CLR: cover property ($fell(tune_err_o));
endmodule

//--- logic/rsq_consts.svh
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
// ==========================================================================
// register word addresses
`define RSQ_A_CTRL      8'h00
`define RSQ_A_RAMP_CFG  8'h01
`define RSQ_A_THR1      8'h02
`define RSQ_A_THR2      8'h03
`define RSQ_A_HYS1      8'h04
`define RSQ_A_HYS2      8'h05
`define RSQ_A_GRAD      8'h06
`define RSQ_A_HOLD1     8'h07
`define RSQ_A_HOLD2     8'h08
`define RSQ_A_OUT_FUNC  8'h09
`define RSQ_A_EMERG     8'h0A
`define RSQ_A_MAN_LEVEL 8'h0B
`define RSQ_A_PERIOD    8'h0C
`define RSQ_A_STATUS    8'h0D
`define RSQ_A_TIMER     8'h0E
// ==========================================================================
// field positions
`define RSQ_CTRL_START  0
`define RSQ_CTRL_STOP   1
`define RSQ_CFG_MODE_LO 0
`define RSQ_CFG_BTN_LO  2
`define RSQ_CFG_BINARY_LO 4
// ==========================================================================
// field codes
`define RSQ_MODE_OFF    2'h0
`define RSQ_MODE_MAN    2'h1
`define RSQ_MODE_AUTO   2'h2
`define RSQ_IN_NONE     2'h0
`define RSQ_IN_START    2'h1
`define RSQ_IN_MANUAL   2'h2
`define RSQ_FN_OFF      4'h0
`define RSQ_FN_CONTROL  4'h1
`define RSQ_FN_MANUAL   4'h2
`define RSQ_FN_END_ON   4'h3
`define RSQ_FN_END_OFF  4'h4
`define RSQ_FN_LATE     4'h5
// ==========================================================================
// reset values and limits
`define RSQ_RST_WORD    16'h0000
`define RSQ_RST_PERIOD  7'h0A
`define RSQ_HOLD_INF    16'hFFFF
`define RSQ_PCT_FULL    7'h64
// ==========================================================================
// timing: output update period in seconds, clock in hertz
`define RSQ_UPDATE_S    1
`define RSQ_CLK_HZ      40000000
`define RSQ_SEC_CYCLES  (`RSQ_CLK_HZ * `RSQ_UPDATE_S)
`endif

//--- logic/rsq_pkg.sv
package rsq_pkg;
  // ========================================================================
  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } rsq_bus_t;

  // ========================================================================
  // program stages, one-hot
  typedef enum logic [5:0] {
    RSQ_IDLE = 6'h01,
    RSQ_ST1  = 6'h02,
    RSQ_ST2  = 6'h04,
    RSQ_ST3  = 6'h08,
    RSQ_ST4  = 6'h10,
    RSQ_END  = 6'h20
  } rsq_stage_t;
endpackage

//--- logic/rsq_tick.sv
`timescale 1ns/1ps
// ==========================================================================
// periodic one-cycle tick
module rsq_tick #(
  parameter int unsigned CYCLES = 40
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  output logic      tick_o
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  logic [W-1:0] cnt;

  // free-running divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == W'(CYCLES - 1));
      cnt    <= (cnt == W'(CYCLES - 1)) ? '0 : cnt + 1'b1;
    end
  end
endmodule

//--- logic/rsq_pwm.sv
`timescale 1ns/1ps
`include "rsq_consts.svh"
// ==========================================================================
// slow pulse train stepped once per tick, period in ticks
module rsq_pwm (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       tick_i,
  input  wire logic [6:0] level_i,
  input  wire logic [6:0] period_i,
  output logic            on_o
);
  logic [6:0]  cnt;
  logic [6:0]  per;
  logic [13:0] pos;
  logic [13:0] lim;

  // a zero period would give no on-time at any level, so treat it as one tick
  assign per = (period_i == 7'h00) ? 7'h01 : period_i;
  assign pos = 14'(cnt) * 14'(`RSQ_PCT_FULL);
  assign lim = 14'(level_i) * 14'(per);
  assign on_o = (pos < lim);

  // position within the period
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 7'h00;
    end else if (tick_i) begin
      cnt <= (cnt + 7'h01 >= per) ? 7'h00 : cnt + 7'h01;
    end
  end
endmodule

//--- test/rsq_plant.sv
`timescale 1ns/1ps
// ==========================================================================
// slow heater: value climbs while the main output is on, sinks while off
module rsq_plant #(
  parameter int unsigned STEP_CYCLES = 8
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        heat_i,
  output logic [15:0]      pv_o
);
  int unsigned cnt;
  // one unit per step keeps the hold bands reachable in a short run
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt  <= 0;
      pv_o <= 16'h0000;
    end else begin
      cnt <= (cnt == STEP_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == STEP_CYCLES - 1) begin
        if (heat_i) pv_o <= pv_o + 16'h0001;
        else if (pv_o != 16'h0000) pv_o <= pv_o - 16'h0001;
      end
    end
  end
endmodule

//--- test/rsq_ramp_seq_test.sv
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_ramp_seq_test;
  import rsq_pkg::*;
  localparam int unsigned SEC = 8;
  logic clk, rstn, t_err, up, dn;
  rsq_bus_t bus;
  logic [15:0] rdata, pv, d;
  logic [2:0] sw;
  rsq_stage_t stg;
  logic tblk, tout, pblk, fm, btn, binary_in, serr;
  logic [6:0] ana;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  // ========================================================================
  // clock, plant and design
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  rsq_plant #(.STEP_CYCLES(SEC)) plant (.clk_i(clk), .resetn_i(rstn), .heat_i(sw[0]), .pv_o(pv));
  rsq_ramp_seq #(.SEC_CYCLES(SEC)) dut (.clk_i(clk), .resetn_i(rstn), .bus_i(bus), .rdata_o(rdata),
    .pv_i(pv), .sensor_err_i(serr), .tune_err_i(t_err), .func_btn_i(btn), .binary_control_input_i(binary_in),
    .key_up_i(up), .key_down_i(dn), .sw_out_o(sw), .ana_level_o(ana), .tune_block_o(tblk),
    .pid_adj_block_o(pblk), .forced_manual_o(fm), .tune_err_o(tout), .stage_o(stg));
  // ========================================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) bus.re <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // ========================================================================
  // scenarios
  task automatic t_ramp;
    int k;
    wr(`RSQ_A_THR1, 16'h0005); wr(`RSQ_A_THR2, 16'h000A);
    wr(`RSQ_A_HYS1, 16'h0002); wr(`RSQ_A_HYS2, 16'h0002);
    wr(`RSQ_A_HOLD1, 16'h0002); wr(`RSQ_A_HOLD2, 16'h0001);
    wr(`RSQ_A_OUT_FUNC, 16'h1351);
    wr(`RSQ_A_RAMP_CFG, 16'h0001);
    wr(`RSQ_A_CTRL, 16'h0001);
    repeat (3 * SEC) @(posedge clk);
    chk({tblk, pblk}, 2'b11);
    chk(sw[2:1], 2'b00);
    k = 0;
    while (stg !== RSQ_END && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (2 * SEC) @(posedge clk);
    chk(16'(stg), 16'(RSQ_END));
    chk(sw, 3'b100);
    // restart from the end state with the after-end pair on outputs 2 and 3
    wr(`RSQ_A_OUT_FUNC, 16'h0341);
    wr(`RSQ_A_CTRL, 16'h0001);
    repeat (3 * SEC) @(posedge clk);
    chk(sw[2:1], 2'b01);
    wr(`RSQ_A_CTRL, 16'h0002);
    $display("ramp program test done");
  endtask
  task automatic t_manual;
    rd(`RSQ_A_PERIOD, d); chk(d, 16'h000A);
    rd(8'h3F, d); chk(d, 16'h0000);
    wr(`RSQ_A_OUT_FUNC, 16'h2002);
    wr(`RSQ_A_MAN_LEVEL, 16'h0096);
    rd(`RSQ_A_MAN_LEVEL, d); chk(d, 16'h0064);
    repeat (3 * SEC) @(posedge clk);
    chk(sw[0], 1'b1);
    chk(ana, 7'h64);
    wr(`RSQ_A_MAN_LEVEL, 16'h0000);
    repeat (3 * SEC) @(posedge clk);
    chk(sw[0], 1'b0);
    chk(ana, 7'h00);
    // analogue on control with the program stopped would sit at 0 without the sensor fault
    wr(`RSQ_A_MAN_LEVEL, 16'h0032);
    wr(`RSQ_A_OUT_FUNC, 16'h1002);
    wr(`RSQ_A_EMERG, 16'h0008);
    serr <= 1'b1;
    repeat (3 * SEC) @(posedge clk);
    chk(ana, 7'h32);
    serr <= 1'b0;
    $display("manual mode test done");
  endtask
  task automatic t_tune_err;
    @(posedge clk) t_err <= 1'b1;
    @(posedge clk) t_err <= 1'b0;
    repeat (3) @(posedge clk);
    chk(tout, 1'b1);
    @(posedge clk) up <= 1'b1;
    repeat (6) @(posedge clk);
    chk(tout, 1'b1);
    dn <= 1'b1;
    repeat (8) @(posedge clk);
    chk(tout, 1'b0);
    up <= 1'b0;
    dn <= 1'b0;
    $display("tune error test done");
  endtask
  task automatic t_forced;
    wr(`RSQ_A_RAMP_CFG, 16'h0021);
    binary_in <= 1'b1;
    repeat (5) @(posedge clk);
    chk(fm, 1'b1);
    binary_in <= 1'b0;
    wr(`RSQ_A_RAMP_CFG, 16'h0009);
    repeat (3) @(posedge clk);
    chk(fm, 1'b0);
    btn <= 1'b1;
    repeat (5) @(posedge clk);
    chk(fm, 1'b1);
    btn <= 1'b0;
    $display("forced manual test done");
  endtask
  initial begin
    rstn = 0;
    bus = '0;
    t_err = 0;
    up = 0;
    dn = 0;
    btn = 0;
    binary_in = 0;
    serr = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_ramp();
    t_manual();
    t_tune_err();
    t_forced();
    end_of_test;
  end
endmodule
